// ===== hdl/opsr_defs.svh
`ifndef OPSR_DEFS_SVH
`define OPSR_DEFS_SVH

`define OPSR_REG_W        16
`define OPSR_TRIG_W       16
`define OPSR_OP_CC_BIT    10
`define OPSR_OP_CV_BIT    8
`define OPSR_OP_MASK      16'h0500
`define OPSR_Q_CE_BIT     13
`define OPSR_Q_VE_BIT     12
`define OPSR_Q_CM_BIT     1
`define OPSR_Q_VM_BIT     0
`define OPSR_Q_MASK       16'h3003
`define OPSR_Q_LATCH_MASK 16'h3000
`define OPSR_SB_OP_BIT    7
`define OPSR_SB_Q_BIT     3
`define OPSR_RST_REG      16'h0000
`define OPSR_RST_TRIG     16'h0000

`endif

// ===== hdl/opsr_pkg.sv
`default_nettype none
`include "opsr_defs.svh"
package opsr_pkg;

   typedef enum logic [3:0] {
      OPSR_NOP      = 4'h0,
      OPSR_TRIG_SET = 4'h1,
      OPSR_TRIG_QRY = 4'h2,
      OPSR_OPC_QRY  = 4'h3,
      OPSR_OPE_SET  = 4'h4,
      OPSR_OPE_QRY  = 4'h5,
      OPSR_OPEV_QRY = 4'h6,
      OPSR_PRESET   = 4'h7,
      OPSR_QC_QRY   = 4'h8,
      OPSR_QE_SET   = 4'h9,
      OPSR_QE_QRY   = 4'ha,
      OPSR_QEV_QRY  = 4'hb
   } opsr_op_t;

   typedef struct packed {
      opsr_op_t                  op;
      logic [`OPSR_REG_W-1:0]    data;
   } opsr_cmd_t;

   // live conditions from the regulation loop, not in this clock domain
   typedef struct packed {
      logic current_fault_flag;
      logic voltage_fault_flag;
      logic current_mode_live;
      logic voltage_mode_live;
   } opsr_live_t;

   typedef struct packed {
      opsr_live_t                sync1;
      opsr_live_t                sync2;
      opsr_live_t                hold_off;
      logic [`OPSR_REG_W-1:0]    operation_live_condition;
      logic [`OPSR_REG_W-1:0]    operation_summary_mask;
      logic [`OPSR_REG_W-1:0]    operation_latched_events;
      logic [`OPSR_REG_W-1:0]    ques_condition;
      logic [`OPSR_REG_W-1:0]    ques_mask;
      logic [`OPSR_REG_W-1:0]    ques_events;
      logic [`OPSR_TRIG_W-1:0]   trig_level;
      logic                      rsp_valid;
      logic [`OPSR_REG_W-1:0]    rsp_data;
      logic                      op_summary;
      logic                      ques_summary;
   } opsr_state_t;

endpackage
`default_nettype wire

// ===== hdl/opsr_top.sv
// Operation
// RULE1 - trigger-level query returns the level last stored by trigger-set
// RULE2 - operation condition shows live unlatched state, 1 while active; code keeps a bit at 0 after preset until its condition goes away once
// RULE3 - bit 10 means current regulation, bit 8 voltage regulation
// RULE4 - bits 15-11, 9 and 7-0 of operation registers carry nothing
// RULE5 - operation register values stay within zero to 1313
// RULE6 - status byte bit 7 is OR of enabled operation events
// RULE7 - enable mask query returns the value last written
// RULE8 - operation event register latches events, read returns then clears
// RULE9 - entering a mode sets its event bit; repeat read gives zero
// RULE10 - preset clears operation and questionable condition registers
// RULE11 - host sets questionable mask error bits to have errors latched; code latches error bits whatever the mask holds
// RULE12 - questionable bits: 13 current err, 12 voltage err, 1 cm, 0 vm
// RULE13 - only error bits latch in questionable events; read clears them
// RULE14 - status byte bit 3 is OR of enabled questionable events
// RULE15 - unused bits read zero, mask writes to them are dropped
// RULE16 - event bit sets when its condition goes inactive to active
`default_nettype none
`include "opsr_defs.svh"
module opsr_top (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  cmd_valid,
   input  wire opsr_pkg::opsr_cmd_t   cmd,
   input  wire opsr_pkg::opsr_live_t  live,
   output logic                       rsp_valid,
   output logic [`OPSR_REG_W-1:0]     rsp_data,
   output logic [7:0]                 status_byte
);

   opsr_pkg::opsr_state_t st;
   opsr_pkg::opsr_state_t next_st;

   logic                   take;
   logic                   preset;
   logic [`OPSR_REG_W-1:0] next_opc;
   logic [`OPSR_REG_W-1:0] next_qc;
   logic [`OPSR_REG_W-1:0] op_rise;
   logic [`OPSR_REG_W-1:0] q_rise;
   opsr_pkg::opsr_live_t   seen;

   // set wins over the read-clear so no event is lost on a read cycle
   function automatic logic [`OPSR_REG_W-1:0] latch_ev(
      input logic [`OPSR_REG_W-1:0] ev,
      input logic [`OPSR_REG_W-1:0] rise,
      input logic                   clr);
      latch_ev = (clr ? `OPSR_RST_REG : ev) | rise;
   endfunction

   // one decode of the command strobe, shared by preset and the clears
   function automatic logic cmd_is(
      input logic                valid,
      input opsr_pkg::opsr_cmd_t c,
      input opsr_pkg::opsr_op_t  code);
      cmd_is = valid && (c.op == code);
   endfunction

   assign take   = cmd_valid && (cmd.op != opsr_pkg::OPSR_NOP);
   assign preset = cmd_is(cmd_valid, cmd, opsr_pkg::OPSR_PRESET);

   always_comb begin
      next_st = st;
      next_st.sync1 = live;
      next_st.sync2 = st.sync1;
      // after preset a condition stays hidden until it goes away once
      seen = st.sync2 & ~st.hold_off;
      next_opc = `OPSR_RST_REG;                             // [RULE4]
      next_opc[`OPSR_OP_CC_BIT] = seen.current_mode_live;   // [RULE3]
      next_opc[`OPSR_OP_CV_BIT] = seen.voltage_mode_live;   // [RULE3]
      next_qc = `OPSR_RST_REG;
      next_qc[`OPSR_Q_CE_BIT] = seen.current_fault_flag;    // [RULE12]
      next_qc[`OPSR_Q_VE_BIT] = seen.voltage_fault_flag;    // [RULE12]
      next_qc[`OPSR_Q_CM_BIT] = seen.current_mode_live;     // [RULE12]
      next_qc[`OPSR_Q_VM_BIT] = seen.voltage_mode_live;     // [RULE12]
      if (preset) begin
         next_opc = `OPSR_RST_REG;                          // [RULE10]
         next_qc  = `OPSR_RST_REG;                          // [RULE10]
         next_st.hold_off = st.sync2;
      end else begin
         next_st.hold_off = st.hold_off & st.sync2;
      end
      next_st.operation_live_condition = next_opc;          // [RULE2]
      next_st.ques_condition = next_qc;
      op_rise = next_opc & ~st.operation_live_condition;    // [RULE16]
      q_rise = next_qc & ~st.ques_condition
               & `OPSR_Q_LATCH_MASK;                        // [RULE13]
      next_st.operation_latched_events = latch_ev(
         st.operation_latched_events, op_rise,
         cmd_is(cmd_valid, cmd, opsr_pkg::OPSR_OPEV_QRY)); // [RULE8] [RULE9]
      next_st.ques_events = latch_ev(st.ques_events, q_rise,
         cmd_is(cmd_valid, cmd, opsr_pkg::OPSR_QEV_QRY));   // [RULE13]
      next_st.rsp_valid = 1'b0;
      next_st.rsp_data  = st.rsp_data;
      if (take) begin
         unique case (cmd.op)
            opsr_pkg::OPSR_TRIG_SET: begin
               next_st.trig_level = cmd.data;               // [RULE1]
            end
            opsr_pkg::OPSR_TRIG_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.trig_level;           // [RULE1]
            end
            opsr_pkg::OPSR_OPC_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.operation_live_condition;
            end
            opsr_pkg::OPSR_OPE_SET: begin
               next_st.operation_summary_mask =
                  cmd.data & `OPSR_OP_MASK;                 // [RULE5] [RULE15]
            end
            opsr_pkg::OPSR_OPE_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.operation_summary_mask; // [RULE7]
            end
            opsr_pkg::OPSR_OPEV_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.operation_latched_events; // [RULE8]
            end
            opsr_pkg::OPSR_PRESET: begin
               next_st.rsp_valid = 1'b0;
            end
            opsr_pkg::OPSR_QC_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.ques_condition;
            end
            opsr_pkg::OPSR_QE_SET: begin
               // mask bits outside the questionable map are dropped
               next_st.ques_mask = cmd.data & `OPSR_Q_MASK; // [RULE15]
            end
            opsr_pkg::OPSR_QE_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.ques_mask;
            end
            opsr_pkg::OPSR_QEV_QRY: begin
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = st.ques_events;          // [RULE13]
            end
            default: begin
               // unknown codes are ignored with no answer
               next_st.rsp_valid = 1'b0;
            end
         endcase
      end
      next_st.op_summary = |(next_st.operation_latched_events
                           & next_st.operation_summary_mask); // [RULE6]
      next_st.ques_summary = |(next_st.ques_events
                             & next_st.ques_mask);           // [RULE14]
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rsp_valid = st.rsp_valid;
   assign rsp_data  = st.rsp_data;

   always_comb begin
      status_byte = 8'h00;
      status_byte[`OPSR_SB_OP_BIT] = st.op_summary;
      status_byte[`OPSR_SB_Q_BIT]  = st.ques_summary;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   trig_readback_a: assert property ( // [RULE1]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_TRIG_SET) ##1
      (cmd_valid && cmd.op == opsr_pkg::OPSR_TRIG_QRY)
      |=> rsp_valid && rsp_data == $past(cmd.data, 2))
      else $error("trigger level readback wrong");

   live_cond_a: assert property ( // [RULE2]
      ($stable(live) [*4]
       ##0 (!$past(preset) && $past(st.hold_off) == '0))
      |-> st.operation_live_condition[`OPSR_OP_CV_BIT]
          == live.voltage_mode_live)
      else $error("operation condition not following live state");

   unused_bits_a: assert property ( // [RULE4]
      (st.operation_live_condition & ~`OPSR_OP_MASK) == '0
      && (st.operation_latched_events & ~`OPSR_OP_MASK) == '0
      && (st.operation_summary_mask & ~`OPSR_OP_MASK) == '0)
      else $error("unused operation bit set");

   range_a: assert property ( // [RULE5]
      rsp_valid && $past(cmd.op) inside {opsr_pkg::OPSR_OPC_QRY,
         opsr_pkg::OPSR_OPE_QRY, opsr_pkg::OPSR_OPEV_QRY}
      |-> rsp_data <= 16'h0521)
      else $error("operation value out of range");

   op_summary_a: assert property ( // [RULE6]
      ##1 status_byte[`OPSR_SB_OP_BIT] ==
      |(st.operation_latched_events & st.operation_summary_mask))
      else $error("operation summary mismatch");

   mask_readback_a: assert property ( // [RULE7]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_OPE_SET) ##1
      (cmd_valid && cmd.op == opsr_pkg::OPSR_OPE_QRY)
      |=> rsp_data == ($past(cmd.data, 2) & `OPSR_OP_MASK))
      else $error("operation mask readback wrong");

   event_clear_a: assert property ( // [RULE8]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_OPEV_QRY)
      |=> rsp_valid && rsp_data == $past(st.operation_latched_events)
          && st.operation_latched_events ==
             (st.operation_live_condition
              & ~$past(st.operation_live_condition)))
      else $error("event read did not return and clear");

   cv_event_a: assert property ( // [RULE9] [RULE16]
      $rose(st.operation_live_condition[`OPSR_OP_CV_BIT])
      |-> st.operation_latched_events[`OPSR_OP_CV_BIT])
      else $error("voltage mode entry not latched");

   preset_clear_a: assert property ( // [RULE10]
      preset |=> st.operation_live_condition == '0
                 && st.ques_condition == '0)
      else $error("preset left condition bits set");

   ques_latch_a: assert property ( // [RULE13]
      (st.ques_events & ~`OPSR_Q_LATCH_MASK) == '0)
      else $error("mode bit latched in questionable events");

   ques_summary_a: assert property ( // [RULE14]
      ##1 status_byte[`OPSR_SB_Q_BIT] == |(st.ques_events & st.ques_mask))
      else $error("questionable summary mismatch");

   trig_store_a: assert property ( // [RULE1]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_TRIG_SET)
      |=> st.trig_level == $past(cmd.data))
      else $error("trigger level not stored");

   // mapping checks skip cycles where a preset hides the condition
   cc_bit_a: assert property ( // [RULE3]
      (!$past(preset) && $past(st.hold_off) == '0)
      |-> st.operation_live_condition[`OPSR_OP_CC_BIT]
          == $past(st.sync2.current_mode_live))
      else $error("current regulation bit misplaced");

   ques_mode_a: assert property ( // [RULE12]
      (!$past(preset) && $past(st.hold_off) == '0)
      |-> st.ques_condition[`OPSR_Q_VM_BIT]
          == $past(st.sync2.voltage_mode_live))
      else $error("questionable voltage mode bit misplaced");

   ques_unused_a: assert property ( // [RULE15]
      (st.ques_condition & ~`OPSR_Q_MASK) == '0
      && (st.ques_mask & ~`OPSR_Q_MASK) == '0)
      else $error("unused questionable bit set");

   mask_write_a: assert property ( // [RULE7]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_OPE_SET)
      |=> st.operation_summary_mask
          == ($past(cmd.data) & `OPSR_OP_MASK))
      else $error("operation mask write not kept");

   ques_mask_a: assert property ( // [RULE15]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_QE_SET)
      |=> st.ques_mask == ($past(cmd.data) & `OPSR_Q_MASK))
      else $error("questionable mask write not kept");

   ques_rise_a: assert property ( // [RULE13] [RULE16]
      $rose(st.ques_condition[`OPSR_Q_CE_BIT])
      |-> st.ques_events[`OPSR_Q_CE_BIT])
      else $error("current error entry not latched");

   ques_clear_a: assert property ( // [RULE13]
      (cmd_valid && cmd.op == opsr_pkg::OPSR_QEV_QRY)
      |=> rsp_valid && rsp_data == $past(st.ques_events)
          && st.ques_events == (st.ques_condition
             & ~$past(st.ques_condition) & `OPSR_Q_LATCH_MASK))
      else $error("questionable event read did not clear");

   // latched bits may only leave through a read
   event_hold_a: assert property ( // [RULE8]
      !(cmd_valid && cmd.op == opsr_pkg::OPSR_OPEV_QRY)
      |=> (st.operation_latched_events
           & $past(st.operation_latched_events))
          == $past(st.operation_latched_events))
      else $error("operation event lost without a read");

   preset_events_a: assert property ( // [RULE10]
      preset |=> st.operation_latched_events
                 == $past(st.operation_latched_events))
      else $error("preset disturbed the event register");

   status_spare_a: assert property ( // [RULE6] [RULE14]
      (status_byte & 8'h77) == 8'h00)
      else $error("spare status byte bit set");

   set_silent_a: assert property ( // [RULE7]
      (cmd_valid && cmd.op inside {opsr_pkg::OPSR_TRIG_SET,
         opsr_pkg::OPSR_OPE_SET, opsr_pkg::OPSR_PRESET,
         opsr_pkg::OPSR_QE_SET})
      |=> !rsp_valid)
      else $error("set command gave an answer");

   answer_source_a: assert property ( // [RULE8]
      rsp_valid |-> $past(cmd_valid)
                    && $past(cmd.op) inside {opsr_pkg::OPSR_TRIG_QRY,
                       opsr_pkg::OPSR_OPC_QRY, opsr_pkg::OPSR_OPE_QRY,
                       opsr_pkg::OPSR_OPEV_QRY, opsr_pkg::OPSR_QC_QRY,
                       opsr_pkg::OPSR_QE_QRY, opsr_pkg::OPSR_QEV_QRY})
      else $error("answer without a query");

endmodule
`default_nettype wire

// ===== sim/opsr_host.sv
`default_nettype none
module opsr_host (
   input  wire logic           clk,
   output logic                cmd_valid,
   output opsr_pkg::opsr_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // one strobe per command, data held up to the taking edge
   // host passes operation values on as given, without a range limit
   // error bits are enabled by the host itself
   task automatic xfer(input opsr_pkg::opsr_op_t op, input logic [15:0] d);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{op: op, data: d};
      @(posedge clk);
      cmd_valid <= 1'b0;
      // released data shows the inverse, never a stale copy
      cmd <= '{op: opsr_pkg::OPSR_NOP, data: ~d};
   endtask

   // two strobes on consecutive edges, as a fast host may send them
   task automatic xfer2(input opsr_pkg::opsr_op_t op1,
                        input logic [15:0]        d1,
                        input opsr_pkg::opsr_op_t op2,
                        input logic [15:0]        d2);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{op: op1, data: d1};
      @(posedge clk);
      cmd <= '{op: op2, data: d2};
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd <= '{op: opsr_pkg::OPSR_NOP, data: ~d2};
   endtask
endmodule
`default_nettype wire

// ===== sim/opsr_top_test.sv
`default_nettype none
module opsr_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [3:0]  live;
      logic [3:0]  op;
      logic [15:0] data;
      logic        rsp;
      logic [15:0] exp;
      logic [7:0]  sb;
   } opsr_row_t;

   logic                 clk = 1'b0;
   logic                 rstn = 1'b0;
   logic                 cmd_valid;
   opsr_pkg::opsr_cmd_t  cmd;
   opsr_pkg::opsr_live_t live = '0;
   logic                 rsp_valid;
   logic [15:0]          rsp_data;
   logic [7:0]           status_byte;
   int                   mismatches = 0;
   int                   n_checks = 0;
   opsr_row_t            rows [16];

   always #20 clk = ~clk;

   opsr_top i_opsr_top (
      .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
      .live(live), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .status_byte(status_byte));
   opsr_host i_opsr_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // live change needs three edges to land, four keeps a margin
   task automatic run(input opsr_row_t r);
      @(posedge clk);
      live <= r.live;
      repeat (4) @(posedge clk);
      i_opsr_host.xfer(opsr_pkg::opsr_op_t'(r.op), r.data);
      // answer stands only for the cycle after the taking edge
      #1;
      chk("rsp_valid", {15'h0, r.rsp}, {15'h0, rsp_valid});
      if (r.rsp) begin
         chk("rsp_data", r.exp, rsp_data);
      end
      repeat (2) @(posedge clk);
      #1;
      chk("status_byte", {8'h0, r.sb}, {8'h0, status_byte});
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      $display("wrong value run length expected done seen hung");
      conclude();
   end

   initial begin
      // live {cf, vf, cm, vm}, op, data, answer, value, status byte
      rows = '{
         '{4'h0, 4'h1, 16'h1234, 1'b0, 16'h0000, 8'h00},
         '{4'h0, 4'h2, 16'h0000, 1'b1, 16'h1234, 8'h00},
         '{4'h0, 4'h4, 16'h0521, 1'b0, 16'h0000, 8'h00},
         '{4'h0, 4'h5, 16'h0000, 1'b1, 16'h0500, 8'h00},
         '{4'h1, 4'h3, 16'h0000, 1'b1, 16'h0100, 8'h80},
         '{4'h1, 4'h6, 16'h0000, 1'b1, 16'h0100, 8'h00},
         '{4'h1, 4'h6, 16'h0000, 1'b1, 16'h0000, 8'h00},
         '{4'h2, 4'h3, 16'h0000, 1'b1, 16'h0400, 8'h80},
         '{4'h2, 4'h6, 16'h0000, 1'b1, 16'h0400, 8'h00},
         '{4'h2, 4'h9, 16'hf00f, 1'b0, 16'h0000, 8'h00},
         '{4'h2, 4'ha, 16'h0000, 1'b1, 16'h3003, 8'h00},
         '{4'ha, 4'h8, 16'h0000, 1'b1, 16'h2002, 8'h08},
         '{4'ha, 4'hb, 16'h0000, 1'b1, 16'h2000, 8'h00},
         '{4'ha, 4'h7, 16'h0000, 1'b0, 16'h0000, 8'h00},
         '{4'ha, 4'h3, 16'h0000, 1'b1, 16'h0000, 8'h00},
         '{4'ha, 4'h8, 16'h0000, 1'b1, 16'h0000, 8'h00}
      };
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         run(rows[i]);
         $display("test %0d done", i);
      end
      // back-to-back strobes: set, then query on the very next edge
      i_opsr_host.xfer2(opsr_pkg::OPSR_TRIG_SET, 16'hbeef,
                        opsr_pkg::OPSR_TRIG_QRY, 16'h0000);
      #1;
      chk("rsp_valid", 16'h0001, {15'h0, rsp_valid});
      chk("rsp_data", 16'hbeef, rsp_data);
      i_opsr_host.xfer2(opsr_pkg::OPSR_OPE_SET, 16'hfeff,
                        opsr_pkg::OPSR_OPE_QRY, 16'h0000);
      #1;
      chk("rsp_data", 16'h0400, rsp_data);
      $display("test back-to-back done");
      // second reset in mid-run, trigger level back to zero
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk("status_byte", 16'h0000, {8'h0, status_byte});
      run('{4'ha, 4'h2, 16'h0000, 1'b1, 16'h0000, 8'h00});
      $display("test reset done");
      // unmapped code must stay silent
      run('{4'ha, 4'hc, 16'h0000, 1'b0, 16'h0000, 8'h00});
      $display("test refused done");
      conclude();
   end
endmodule
`default_nettype wire
